// file: bbie_defines.vh
// constants for the byte/bit instruction executor
// assumes nothing; definitions only
`ifndef BBIE_DEFINES_VH
`define BBIE_DEFINES_VH
// phases of one instruction cycle
`define BBIE_PH_DECODE  2'h0
`define BBIE_PH_READ    2'h1
`define BBIE_PH_PROCESS 2'h2
`define BBIE_PH_WRITE   2'h3
// opcode patterns
`define BBIE_OP_BTSC    4'hB
`define BBIE_OP_BTSS    4'hA
`define BBIE_OP_CMPL    6'h07
`define BBIE_OP_CPSEQ   7'h31
`define BBIE_OP_SECOND  4'hF
// two-word first-word patterns
`define BBIE_OP_MOVFF   4'hC
`define BBIE_OP_GOTO    8'hEF
`define BBIE_OP_CALL    7'h76
`define BBIE_OP_LFSR    8'hEE
// field positions
`define BBIE_D_BIT      9
`define BBIE_A_BIT      8
// status bit positions
`define BBIE_ST_N       4
`define BBIE_ST_Z       2
// reset values
`define BBIE_W_RST      8'h00
`define BBIE_ST_RST     8'h00
`endif

// file: bbie_phase_gen.v
// four-phase sequencer for one instruction cycle
// assumes one core_clk period per oscillator period
`timescale 1ns/1ps
module bbie_phase_gen (
    core_clk,
    rst,
    phase
);
    input  wire       core_clk;  // clock
    input  wire       rst;       // sync reset
    output reg  [1:0] phase;     // current phase
    `include "bbie_defines.vh"
    // phase walks 0..3 and wraps
    always @(posedge core_clk) begin
        if (rst) begin
            phase <= `BBIE_PH_DECODE;
        end else begin
            phase <= phase + 2'h1;
        end
    end
endmodule // bbie_phase_gen

// file: bbie_classify.v
// combinational instruction classifier
// assumes a 16-bit word from program memory
`timescale 1ns/1ps
module bbie_classify (
    word,
    is_btsc,
    is_btss,
    is_cmpl,
    is_cpseq,
    is_second,
    is_two_word
);
    input  wire [15:0] word;        // instruction word
    output wire        is_btsc;     // bit test skip clear
    output wire        is_btss;     // bit test skip set
    output wire        is_cmpl;     // complement file
    output wire        is_cpseq;    // compare skip equal
    output wire        is_second;   // second word pattern
    output wire        is_two_word; // first word of a two-word op
    `include "bbie_defines.vh"
    assign is_btsc   = (word[15:12] == `BBIE_OP_BTSC);
    assign is_btss   = (word[15:12] == `BBIE_OP_BTSS);
    assign is_cmpl   = (word[15:10] == `BBIE_OP_CMPL);
    assign is_cpseq  = (word[15:9]  == `BBIE_OP_CPSEQ);
    assign is_second = (word[15:12] == `BBIE_OP_SECOND);
    // four two-word instructions
    assign is_two_word = (word[15:12] == `BBIE_OP_MOVFF) ||
                         (word[15:8] == `BBIE_OP_GOTO) ||
                         (word[15:9] == `BBIE_OP_CALL) ||
                         (word[15:8] == `BBIE_OP_LFSR);
endmodule // bbie_classify

// file: bbie_exec.v
// decode and execution control for an 8-bit core
// assumes program memory supplies instr_word for the current cycle,
// and data memory answers fr_rdata combinationally from fr_addr
//
// Summary of operation
// - one word usually; four ops use two
// - d=0 to working register, d=1 to file
// - second word has top four bits one
// - one cycle; two when skipping or branching
// - two-word instructions take two cycles
// - four clock phases per instruction cycle
// - file operands always read before write
// - port write-back may capture pin levels
// - a=0 access bank, a=1 bank select
// - 1011 tests bit, skips if clear
// - 1010 tests bit, skips if set
// - skip discards fetch; three if two-word
// - complement file, destination, flags N Z
// - compare with working register, skip equal
`timescale 1ns/1ps
module bbie_exec #(
    parameter DW = 8   // data width
) (
    core_clk,
    rst,
    instr_word,
    bank_select_register,
    fr_rdata,
    fr_addr,
    fr_rd,
    fr_wr,
    fr_wdata,
    working_register,
    status_q,
    skip_q,
    nop_cycle_q,
    phase_q,
    cycle_end_q
);
    input  wire          core_clk;             // clock
    input  wire          rst;                  // sync reset, high
    input  wire [15:0]   instr_word;           // fetched instruction
    input  wire [3:0]    bank_select_register; // bank number
    input  wire [DW-1:0] fr_rdata;             // file read data
    output reg  [11:0]   fr_addr;              // file address
    output reg           fr_rd;                // read strobe
    output reg           fr_wr;                // write strobe
    output reg  [DW-1:0] fr_wdata;             // write data
    output reg  [DW-1:0] working_register;     // working register
    output reg  [7:0]    status_q;             // status flags
    output reg           skip_q;               // skip taken this cycle
    output reg           nop_cycle_q;          // executing a forced no-op
    output reg  [1:0]    phase_q;              // phase copy
    output reg           cycle_end_q;          // pulse at last phase
    `include "bbie_defines.vh"

    wire [1:0] phase;     // sequencer phase
    wire is_btsc;         // decoded classes
    wire is_btss;
    wire is_cmpl;
    wire is_cpseq;
    wire is_second;
    wire is_two_word;

    bbie_phase_gen u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .phase    (phase)
    );

    bbie_classify u_cls (
        .word        (instr_word),
        .is_btsc     (is_btsc),
        .is_btss     (is_btss),
        .is_cmpl     (is_cmpl),
        .is_cpseq    (is_cpseq),
        .is_second   (is_second),
        .is_two_word (is_two_word)
    );

    reg [15:0]   ir_q;        // latched instruction
    reg          c_btsc_q;    // latched class flags
    reg          c_btss_q;
    reg          c_cmpl_q;
    reg          c_cpseq_q;
    reg          c_two_q;     // decoded op is two-word
    reg          kill_q;      // cycle runs as no-op
    reg [1:0]    pend_q;      // no-op cycles still owed
    reg [DW-1:0] data_q;      // data read in phase 2
    reg [DW-1:0] res_q;       // processed result
    reg          take_q;      // skip decision
    wire [2:0]   bitsel;      // bit number field
    wire         dest_file;   // destination select
    wire         use_bank;    // access select

    assign bitsel    = ir_q[11:9];
    assign dest_file = ir_q[`BBIE_D_BIT];
    assign use_bank  = ir_q[`BBIE_A_BIT];

    // four phase pipeline of one instruction cycle
    always @(posedge core_clk) begin
        if (rst) begin
            ir_q             <= 16'h0000;
            c_btsc_q         <= 1'b0;
            c_btss_q         <= 1'b0;
            c_cmpl_q         <= 1'b0;
            c_cpseq_q        <= 1'b0;
            c_two_q          <= 1'b0;
            kill_q           <= 1'b0;
            pend_q           <= 2'h0;
            data_q           <= {DW{1'b0}};
            res_q            <= {DW{1'b0}};
            take_q           <= 1'b0;
            fr_addr          <= 12'h000;
            fr_rd            <= 1'b0;
            fr_wr            <= 1'b0;
            fr_wdata         <= {DW{1'b0}};
            working_register <= `BBIE_W_RST;
            status_q         <= `BBIE_ST_RST;
            skip_q           <= 1'b0;
            nop_cycle_q      <= 1'b0;
            phase_q          <= 2'h0;
            cycle_end_q      <= 1'b0;
        end else begin
            phase_q     <= phase;
            fr_rd       <= 1'b0;
            fr_wr       <= 1'b0;
            cycle_end_q <= (phase == `BBIE_PH_WRITE);
            case (phase)
                `BBIE_PH_DECODE: begin
                    // decode, or burn an owed no-op cycle
                    ir_q      <= instr_word;
                    skip_q    <= 1'b0;
                    take_q    <= 1'b0;
                    if (pend_q != 2'h0) begin
                        kill_q      <= 1'b1;
                        nop_cycle_q <= 1'b1;
                        pend_q      <= pend_q - 2'h1;
                    end else begin
                        // a lone second word decodes to nothing
                        kill_q      <= is_second;
                        nop_cycle_q <= is_second;
                    end
                    c_btsc_q  <= is_btsc;
                    c_btss_q  <= is_btss;
                    c_cmpl_q  <= is_cmpl;
                    c_cpseq_q <= is_cpseq;
                    c_two_q   <= is_two_word;
                end
                `BBIE_PH_READ: begin
                    // read the file register, even before a write
                    if (!kill_q && (c_btsc_q || c_btss_q || c_cmpl_q || c_cpseq_q)) begin
                        fr_rd   <= 1'b1;
                        fr_addr <= use_bank ? {bank_select_register, ir_q[7:0]}
                                            : {4'h0, ir_q[7:0]};
                    end
                    // two-word op owes one cycle for its second word
                    if (!kill_q && c_two_q) begin
                        pend_q <= 2'h1;
                    end
                end
                `BBIE_PH_PROCESS: begin
                    // process the data read in the previous phase
                    data_q <= fr_rdata;
                    res_q  <= ~fr_rdata;
                    if (!kill_q) begin
                        if (c_btsc_q) begin
                            take_q <= ~fr_rdata[bitsel];
                        end else if (c_btss_q) begin
                            take_q <= fr_rdata[bitsel];
                        end else if (c_cpseq_q) begin
                            take_q <= ((fr_rdata - working_register) == {DW{1'b0}});
                        end else begin
                            take_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    // write destination; test-only ops write nothing
                    if (!kill_q && c_cmpl_q) begin
                        if (dest_file) begin
                            fr_wr    <= 1'b1;
                            fr_wdata <= res_q;
                        end else begin
                            working_register <= res_q;
                        end
                        status_q[`BBIE_ST_N] <= res_q[DW-1];
                        status_q[`BBIE_ST_Z] <= (res_q == {DW{1'b0}});
                    end
                    // skip discards the prefetched word
                    if (!kill_q && take_q) begin
                        skip_q <= 1'b1;
                        pend_q <= 2'h1;
                    end
                end
            endcase
            // the word skipped turned out to be a first word
            if (phase == `BBIE_PH_DECODE && pend_q == 2'h1 && skip_q && is_two_word) begin
                pend_q <= 2'h1;
            end
        end
    end
endmodule // bbie_exec

// file: bbie_exec_monitor.sv
// checker: timing relations seen at the executor ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module bbie_exec_monitor #(
    parameter DW = 8
) (
    input wire logic          core_clk,
    input wire logic          rst,
    input wire logic [11:0]   fr_addr,
    input wire logic          fr_rd,
    input wire logic          fr_wr,
    input wire logic [DW-1:0] working_register,
    input wire logic [7:0]    status_q,
    input wire logic          skip_q,
    input wire logic          nop_cycle_q,
    input wire logic [1:0]    phase_q,
    input wire logic          cycle_end_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // three quiet clocks, then the next end of cycle
    sequence s_gap;
        !cycle_end_q [*3] ##1 cycle_end_q;
    endsequence
    a_phase_step: assert property (!$past(rst) && !$past(rst, 2) |-> phase_q == $past(phase_q) + 2'h1)
        else $error("phase did not advance by one");
    a_cycle_period: assert property (cycle_end_q |=> s_gap)
        else $error("cycle end not every fourth clock");
    a_read_pulse: assert property (fr_rd |=> !fr_rd)
        else $error("read strobe longer than one clock");
    a_read_first: assert property (fr_wr |-> $past(fr_rd, 1) || $past(fr_rd, 2) || $past(fr_rd, 3))
        else $error("file write without a read before it");
    a_write_addr: assert property (fr_wr |-> $stable(fr_addr))
        else $error("write address differs from read address");
    a_skip_nowrite: assert property (skip_q |-> !fr_wr)
        else $error("test-only instruction wrote the file");
    a_nop_noread: assert property (nop_cycle_q |-> !fr_rd)
        else $error("forced no-op cycle read the file");
    a_flags_nz: assert property ((status_q & 8'hEB) == 8'h00)
        else $error("status bit other than N or Z set");
    a_dest_one: assert property (fr_wr |-> $stable(working_register))
        else $error("working register changed on a file write");
    a_skip_nop: assert property (skip_q |=> nop_cycle_q)
        else $error("skip not followed by a no-op cycle");
endmodule // bbie_exec_monitor
bind bbie_exec bbie_exec_monitor #(.DW(DW)) u_mon (.core_clk(core_clk), .rst(rst), .fr_addr(fr_addr),
    .fr_rd(fr_rd), .fr_wr(fr_wr), .working_register(working_register), .status_q(status_q),
    .skip_q(skip_q), .nop_cycle_q(nop_cycle_q), .phase_q(phase_q), .cycle_end_q(cycle_end_q));

// file: bbie_mem_model.sv
// file register space model: combinational read, clocked write
// assumes the bench preloads the cells it reads
`timescale 1ns/1ps
module bbie_mem_model (
    input wire logic        core_clk,
    input wire logic [11:0] fr_addr,
    input wire logic        fr_wr,
    input wire logic [7:0]  fr_wdata,
    output logic [7:0]      fr_rdata
);
    logic [7:0] ram [0:4095]; // whole banked space
    // read answers at once from the address
    assign fr_rdata = ram[fr_addr];
    // write lands on the strobe edge
    always @(posedge core_clk) begin
        if (fr_wr) begin
            ram[fr_addr] <= fr_wdata;
        end
    end
endmodule // bbie_mem_model

// file: byte_bit_instruction_exec_tb.sv
// random and corner tests of the byte/bit executor
// assumes words are held whole four-clock cycles, first after reset release
`timescale 1ns/1ps
module byte_bit_instruction_exec_tb;
    logic        core_clk, rst;
    logic [15:0] instr_word;
    logic [3:0]  bank_select_register;
    wire  [7:0]  fr_rdata, fr_wdata, working_register, status_q;
    wire  [11:0] fr_addr;
    wire  [1:0]  phase_q;
    wire         fr_rd, fr_wr, skip_q, nop_cycle_q, cycle_end_q;
    int          num_errors = 0;
    int          checked = 0;
    logic [31:0] seed = 32'hBF02;
    bbie_exec uut (.core_clk(core_clk), .rst(rst), .instr_word(instr_word),
        .bank_select_register(bank_select_register), .fr_rdata(fr_rdata), .fr_addr(fr_addr), .fr_rd(fr_rd),
        .fr_wr(fr_wr), .fr_wdata(fr_wdata), .working_register(working_register), .status_q(status_q),
        .skip_q(skip_q), .nop_cycle_q(nop_cycle_q), .phase_q(phase_q), .cycle_end_q(cycle_end_q));
    bbie_mem_model mem (.core_clk(core_clk), .fr_addr(fr_addr), .fr_wr(fr_wr), .fr_wdata(fr_wdata),
        .fr_rdata(fr_rdata));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // skip decision for test kinds 2..4
    function automatic logic exp_skip(input int k, input logic [2:0] b, input logic [7:0] v, w);
        return (k == 2) ? !v[b] : (k == 3) ? v[b] : (k == 4) ? (v == w) : 1'b0;
    endfunction
    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // present one word and hold it for n clocks
    task automatic step(input logic [15:0] w, input int n);
        instr_word <= w;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge core_clk);
        num_errors++;
        test_done();
    end
    initial begin
        logic [7:0] w_ref, st_ref, pr_ref, v, res, f;
        logic [11:0] ad;
        logic [15:0] wd;
        logic sk, a;
        int k;
        rst = 1'b1;
        instr_word = 16'h0000;
        bank_select_register = 4'h0;
        w_ref = 8'h00;
        st_ref = 8'h00;
        pr_ref = 8'h00;
        mem.ram[12'h0FF] = 8'h00;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            k = seed[18:16] % 5;
            a = seed[3];
            f = seed[15:8];
            v = seed[27] ? w_ref : seed[26:19];
            ad = a ? {seed[7:4], f} : {4'h0, f};
            if (ad == 12'h0FF) f = 8'hFE;
            ad = a ? {seed[7:4], f} : {4'h0, f};
            wd = (k < 2) ? {6'h07, k[0], a, f} : (k == 4) ? {7'h31, a, f} : {k == 2 ? 4'hB : 4'hA, seed[2:0], a, f};
            bank_select_register <= seed[7:4];
            mem.ram[ad] = v;
            sk = exp_skip(k, seed[2:0], v, w_ref);
            res = ~v;
            if (k < 2) begin
                st_ref[4] = res[7];
                st_ref[2] = (res == 8'h00);
            end
            if (k == 0) w_ref = res;
            step(wd, 4);
            step(16'h1EFF, 2);
            check("working", working_register, w_ref);
            check("skipnop", nop_cycle_q, sk);
            check("status", status_q, st_ref);
            if (!sk) pr_ref = ~pr_ref;
            st_ref[4] = sk ? st_ref[4] : pr_ref[7];
            st_ref[2] = sk ? st_ref[2] : (pr_ref == 8'h00);
            repeat (2) @(posedge core_clk);
            step(16'h0000, 4);
            check("target", mem.ram[ad], (k == 1) ? res : v);
            check("probe", mem.ram[12'h0FF], pr_ref);
        end
        mem.ram[12'h010] = 8'h01;
        for (int j = 0; j < 6; j++) begin
            wd = (j / 2 == 0) ? 16'hEF00 : (j / 2 == 1) ? 16'hEC00 : 16'hEE00;
            step(j[0] ? 16'hA010 : 16'hB010, 4);
            step(wd, 4);
            step(16'h1EFF, 8);
            step(16'h0000, 4);
            pr_ref = ~pr_ref;
            check("twoword", mem.ram[12'h0FF], pr_ref);
            check("working2", working_register, w_ref);
        end
        step(16'hF1FF, 4);
        check("lonenop", nop_cycle_q, 1'b1);
        step(16'h0000, 4);
        check("lone", mem.ram[12'h0FF], pr_ref);
        check("working3", working_register, w_ref);
        test_done();
    end
endmodule // byte_bit_instruction_exec_tb
